// File: logic/fpda_map.vh
/*
  Register offsets, command codes, reset values and limits for the flash
  program and data access block. Assumes a 32-bit APB with byte addresses.
*/
`ifndef FPDA_MAP_VH
`define FPDA_MAP_VH
// ==========================================
// Register byte offsets
`define FPDA_OFF_DATA0   8'h00
`define FPDA_OFF_DATA3   8'h0c
`define FPDA_OFF_AHI     8'h10
`define FPDA_OFF_ALO     8'h14
`define FPDA_OFF_CMD     8'h18
`define FPDA_OFF_CTRL    8'h1c
`define FPDA_OFF_STAT    8'h20
// ==========================================
// Field positions
`define FPDA_CTRL_USER_RUNTIME_PROGRAM_MODE  0
`define FPDA_CTRL_BOOT   1
`define FPDA_STAT_BUSY   0
`define FPDA_STAT_SER    1
`define FPDA_STAT_PAR    2
`define FPDA_STAT_USER_RUNTIME_PROGRAM_MODE  3
// ==========================================
// Command codes
`define FPDA_CMD_READ    8'h01
`define FPDA_CMD_WRITE   8'h02
`define FPDA_CMD_VERIFY  8'h04
`define FPDA_CMD_ERPAGE  8'h05
`define FPDA_CMD_ERALL   8'h06
`define FPDA_CMD_RDBYTE  8'h81
`define FPDA_CMD_WRBYTE  8'h82
`define FPDA_VERIFY_BAD  8'hff
// ==========================================
// Reset values
`define FPDA_RST_BYTE    8'h00
`define FPDA_RST_DATA    32'h0000_0000
`define FPDA_RST_SYNC    35'h0_0000_0001
`define FPDA_ERASED      8'hff
// ==========================================
// Address limits and counts
`define FPDA_PROG_TOP    16'hf800
`define FPDA_USER_RUNTIME_PROGRAM_MODE_TOP   16'he000
`define FPDA_USER_RUNTIME_PROGRAM_MODE_HI    8'he0
`define FPDA_BOOT_VEC    16'he000
`define FPDA_RST_VEC     16'h0000
`define FPDA_PAGE_BYTES  13'd4
`define FPDA_ONE_BYTE    13'd1
`define FPDA_ARRAY_BYTES 13'd4096
`define FPDA_XRAM_BYTES  13'd256
`define FPDA_SETTLE      3'd7
// ==========================================
// Program array operations
`define FPDA_PF_BYTE     2'd0
`define FPDA_PF_PAGE     2'd1
`define FPDA_PF_LOW      2'd2
`define FPDA_PF_ALL      2'd3
`endif

// File: logic/fpda_ram.v
/*
  Byte-wide single-port array holding the data flash contents.
  Assumes one access per cycle; read data come from a register.
*/
`timescale 1ns/100ps
module fpda_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================
  // Access
  always @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule

// File: logic/fpda_top.v
/*
  Flash program and data access: APB registers, data flash sequencer,
  runtime program write path, serial download and parallel programming.
  Assumes the program flash macro answers pf_req with pf_ack, and that
  external XRAM returns data one cycle after xram_addr.
*/
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "fpda_map.vh"
module fpda_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        program_strobe_pin,
  input  wire        par_en_pin,
  input  wire        ale_pin,
  input  wire [7:0]  p0_pin,
  input  wire [7:0]  p1_pin,
  input  wire [7:0]  p2_pin,
  input  wire [7:0]  p3_pin,
  input  wire        dl_valid,
  input  wire        dl_erase,
  input  wire [15:0] dl_addr,
  input  wire [7:0]  dl_data,
  output wire        dl_ready,
  output wire [7:0]  xram_addr,
  input  wire [7:0]  xram_rdata,
  output reg         pf_req,
  output reg  [1:0]  pf_op,
  output reg  [15:0] pf_addr,
  output reg  [7:0]  pf_wdata,
  input  wire        pf_ack,
  input  wire [15:0] code_addr,
  output wire        code_in_array,
  output reg  [15:0] reset_vector
);
  localparam S_IDLE = 5'b00001;
  localparam S_DRD  = 5'b00010;
  localparam S_DWR  = 5'b00100;
  localparam S_PRD  = 5'b01000;
  localparam S_PWT  = 5'b10000;
  localparam SW     = 35;
  localparam [SW-1:0] SYNC_INIT = `FPDA_RST_SYNC;

  reg  [SW-1:0] sync_a;
  reg  [SW-1:0] sync_b;
  reg  [SW-1:0] sync_c;
  reg  [SW-1:0] flt;
  reg  [2:0]    settle;
  reg           strap_done;
  reg           ser_mode;
  reg  [31:0]   page_data;
  reg  [7:0]    addr_hi;
  reg  [7:0]    addr_lo;
  reg  [7:0]    cmd_reg;
  reg           user_runtime_program_mode_mode;
  reg           boot_en;
  reg  [4:0]    st;
  reg  [12:0]   cnt;
  reg  [12:0]   lim;
  reg  [11:0]   base;
  reg           fill_ff;
  reg           cmp;
  reg           mis;
  reg           rd_pend;
  reg  [1:0]    rd_idx;
  reg           issued;
  wire          par_mode;
  wire          ale_rise;
  wire          user_runtime_program_mode_eff;
  wire          busy;
  wire          apb_wr;
  wire          apb_setup_rd;
  wire          mapped;
  wire          wr_cmd;
  wire [11:0]   page_base;
  wire [11:0]   byte_base;
  wire [15:0]   ul_addr;
  wire [11:0]   mem_addr;
  wire          mem_we;
  wire [7:0]    mem_wdata;
  wire [7:0]    mem_rdata;
  wire [7:0]    par_data;
  wire [15:0]   par_addr;
  wire [7:0]    par_cfg;
  wire [12:0]   cnt_inc;

  // ==========================================
  // Pin synchronisers and glitch filter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= `FPDA_RST_SYNC;
      sync_b <= `FPDA_RST_SYNC;
      sync_c <= `FPDA_RST_SYNC;
    end
    else
    begin
      sync_a <= {p3_pin, p2_pin, p1_pin, p0_pin, ale_pin, par_en_pin, program_strobe_pin};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1)
    begin : g_flt
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flt[gi] <= SYNC_INIT[gi];
        else if (sync_b[gi] == sync_c[gi])
          flt[gi] <= sync_c[gi];
      end
    end
  endgenerate

  assign par_mode = flt[1];
  assign ale_rise = par_mode & (sync_b[2] == sync_c[2]) & sync_c[2] & ~flt[2];
  assign par_data = flt[10:3];
  assign par_addr = {flt[26:19], flt[18:11]};
  assign par_cfg  = flt[34:27];

  // ==========================================
  // Strap capture after reset release
  // Waits out the filter so the chain's reset value is never taken
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle     <= 3'd0;
      strap_done <= 1'b0;
      ser_mode   <= 1'b0;
    end
    else if (!strap_done)
    begin
      settle <= settle + 3'd1;
      if (settle == `FPDA_SETTLE)
      begin
        strap_done <= 1'b1;
        ser_mode   <= ~flt[0];
      end
    end
  end

  // ==========================================
  // Decode
  assign user_runtime_program_mode_eff    = user_runtime_program_mode_mode & ~ser_mode & ~par_mode;
  assign busy         = (st != S_IDLE);
  assign apb_wr       = psel & penable & pwrite;
  assign apb_setup_rd = psel & ~penable & ~pwrite;
  assign mapped       = (paddr[1:0] == 2'b00) & (paddr <= `FPDA_OFF_STAT);
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~mapped;
  assign wr_cmd       = apb_wr & (paddr == `FPDA_OFF_CMD) & ~busy;
  assign page_base    = {addr_hi[1:0], addr_lo, 2'b00};
  assign byte_base    = {addr_hi[3:0], addr_lo};
  assign ul_addr      = {addr_hi, addr_lo};
  assign cnt_inc      = cnt + 13'd1;
  assign xram_addr    = cnt[7:0];
  assign dl_ready     = ser_mode & ~pf_req & ~busy;
  assign code_in_array = (code_addr < `FPDA_PROG_TOP);

  // ==========================================
  // Data array
  assign mem_addr  = base + cnt[11:0];
  assign mem_we    = (st == S_DWR) & (cnt < lim);
  assign mem_wdata = fill_ff ? `FPDA_ERASED : page_data[8*cnt[1:0] +: 8];

  fpda_ram #(
    .AW (12),
    .DW (8)
  ) i_fpda_ram (
    .clk   (pclk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // ==========================================
  // APB read data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup_rd)
    begin
      prdata <= 32'h0000_0000;
      if (paddr <= `FPDA_OFF_DATA3 && paddr[1:0] == 2'b00)
        prdata[7:0] <= page_data[8*paddr[3:2] +: 8];
      else if (paddr == `FPDA_OFF_AHI)
        prdata[7:0] <= addr_hi;
      else if (paddr == `FPDA_OFF_ALO)
        prdata[7:0] <= addr_lo;
      else if (paddr == `FPDA_OFF_CMD)
        prdata[7:0] <= cmd_reg;
      else if (paddr == `FPDA_OFF_CTRL)
        prdata[1:0] <= {boot_en, user_runtime_program_mode_mode};
      else if (paddr == `FPDA_OFF_STAT)
        prdata[3:0] <= {user_runtime_program_mode_eff, par_mode, ser_mode, busy};
    end
  end

  // ==========================================
  // Boot vector
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_vector <= `FPDA_RST_VEC;
    else
      reset_vector <= boot_en ? `FPDA_BOOT_VEC : `FPDA_RST_VEC;
  end

  // ==========================================
  // Registers and sequencer
  // Writes other than control are ignored while busy, so a
  // running transfer keeps its page and data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_data  <= `FPDA_RST_DATA;
      addr_hi    <= `FPDA_RST_BYTE;
      addr_lo    <= `FPDA_RST_BYTE;
      cmd_reg    <= `FPDA_RST_BYTE;
      user_runtime_program_mode_mode <= 1'b0;
      boot_en    <= 1'b0;
      st         <= S_IDLE;
      cnt        <= 13'd0;
      lim        <= 13'd0;
      base       <= 12'd0;
      fill_ff    <= 1'b0;
      cmp        <= 1'b0;
      mis        <= 1'b0;
      rd_pend    <= 1'b0;
      rd_idx     <= 2'd0;
      issued     <= 1'b0;
      pf_req     <= 1'b0;
      pf_op      <= `FPDA_PF_BYTE;
      pf_addr    <= 16'h0000;
      pf_wdata   <= 8'h00;
    end
    else
    begin
      if (apb_wr && paddr == `FPDA_OFF_CTRL)
      begin
        user_runtime_program_mode_mode <= pwdata[`FPDA_CTRL_USER_RUNTIME_PROGRAM_MODE];
        boot_en    <= pwdata[`FPDA_CTRL_BOOT];
      end
      if (apb_wr && !busy)
      begin
        if (paddr <= `FPDA_OFF_DATA3 && paddr[1:0] == 2'b00)
          page_data[8*paddr[3:2] +: 8] <= pwdata[7:0];
        if (paddr == `FPDA_OFF_AHI)
          addr_hi <= pwdata[7:0];
        if (paddr == `FPDA_OFF_ALO)
          addr_lo <= pwdata[7:0];
      end
      if (pf_req && pf_ack)
        pf_req <= 1'b0;
      case (st)
        S_IDLE:
        begin
          cnt     <= 13'd0;
          mis     <= 1'b0;
          rd_pend <= 1'b0;
          issued  <= 1'b0;
          if (wr_cmd)
          begin
            cmd_reg <= pwdata[7:0];
            if (!user_runtime_program_mode_eff)
            begin
              case (pwdata[7:0])
                `FPDA_CMD_READ:
                begin
                  base <= page_base;
                  lim  <= `FPDA_PAGE_BYTES;
                  cmp  <= 1'b0;
                  st   <= S_DRD;
                end
                `FPDA_CMD_RDBYTE:
                begin
                  base <= byte_base;
                  lim  <= `FPDA_ONE_BYTE;
                  cmp  <= 1'b0;
                  st   <= S_DRD;
                end
                `FPDA_CMD_VERIFY:
                begin
                  base <= page_base;
                  lim  <= `FPDA_PAGE_BYTES;
                  cmp  <= 1'b1;
                  st   <= S_DRD;
                end
                `FPDA_CMD_WRITE:
                begin
                  base    <= page_base;
                  lim     <= `FPDA_PAGE_BYTES;
                  fill_ff <= 1'b0;
                  st      <= S_DWR;
                end
                `FPDA_CMD_WRBYTE:
                begin
                  base    <= byte_base;
                  lim     <= `FPDA_ONE_BYTE;
                  fill_ff <= 1'b0;
                  st      <= S_DWR;
                end
                `FPDA_CMD_ERPAGE:
                begin
                  base    <= page_base;
                  lim     <= `FPDA_PAGE_BYTES;
                  fill_ff <= 1'b1;
                  st      <= S_DWR;
                end
                `FPDA_CMD_ERALL:
                begin
                  base    <= 12'd0;
                  lim     <= `FPDA_ARRAY_BYTES;
                  fill_ff <= 1'b1;
                  st      <= S_DWR;
                end
                default:
                  st <= S_IDLE;
              endcase
            end
            else
            begin
              case (pwdata[7:0])
                `FPDA_CMD_WRITE:
                begin
                  lim <= `FPDA_XRAM_BYTES;
                  if (addr_hi < `FPDA_USER_RUNTIME_PROGRAM_MODE_HI)
                    st <= S_PRD;
                end
                `FPDA_CMD_ERPAGE:
                begin
                  lim <= `FPDA_ONE_BYTE;
                  if (ul_addr < `FPDA_USER_RUNTIME_PROGRAM_MODE_TOP)
                  begin
                    pf_req  <= 1'b1;
                    pf_op   <= `FPDA_PF_PAGE;
                    pf_addr <= {addr_hi, addr_lo[7:6], 6'd0};
                    issued  <= 1'b1;
                    st      <= S_PWT;
                  end
                end
                `FPDA_CMD_ERALL:
                begin
                  lim     <= `FPDA_ONE_BYTE;
                  pf_req  <= 1'b1;
                  pf_op   <= `FPDA_PF_LOW;
                  pf_addr <= 16'h0000;
                  issued  <= 1'b1;
                  st      <= S_PWT;
                end
                default:
                  st <= S_IDLE;
              endcase
            end
          end
          else if (!pf_req && dl_valid && ser_mode)
          begin
            if (dl_erase || dl_addr < `FPDA_PROG_TOP)
            begin
              pf_req   <= 1'b1;
              pf_op    <= dl_erase ? `FPDA_PF_ALL : `FPDA_PF_BYTE;
              pf_addr  <= dl_addr;
              pf_wdata <= dl_data;
            end
          end
          else if (!pf_req && ale_rise && !ser_mode && par_cfg[1:0] != `FPDA_PF_ALL)
          begin
            // A strobe arriving while the flash is still busy is dropped
            pf_req   <= 1'b1;
            pf_op    <= (par_cfg[1:0] == 2'd2) ? `FPDA_PF_ALL : par_cfg[1:0];
            pf_addr  <= par_addr;
            pf_wdata <= par_data;
          end
        end
        S_DRD:
        begin
          if (cnt < lim)
            cnt <= cnt_inc;
          rd_pend <= (cnt < lim);
          rd_idx  <= cnt[1:0];
          if (rd_pend)
          begin
            if (cmp)
              mis <= mis | (mem_rdata != page_data[8*rd_idx +: 8]);
            else
              page_data[8*rd_idx +: 8] <= mem_rdata;
          end
          if (cnt == lim && !rd_pend)
          begin
            if (cmp)
              cmd_reg <= mis ? `FPDA_VERIFY_BAD : `FPDA_RST_BYTE;
            st <= S_IDLE;
          end
        end
        S_DWR:
        begin
          cnt <= cnt_inc;
          if (cnt_inc >= lim)
            st <= S_IDLE;
        end
        S_PRD:
        begin
          issued <= 1'b0;
          st     <= S_PWT;
        end
        S_PWT:
        begin
          if (!issued)
          begin
            pf_req   <= 1'b1;
            pf_op    <= `FPDA_PF_BYTE;
            pf_addr  <= {addr_hi, cnt[7:0]};
            pf_wdata <= xram_rdata;
            issued   <= 1'b1;
          end
          else if (pf_req && pf_ack)
          begin
            cnt <= cnt_inc;
            st  <= (cnt_inc >= lim) ? S_IDLE : S_PRD;
          end
        end
        default:
          st <= S_IDLE;
      endcase
    end
  end
endmodule

// File: verification/fpda_top_chk.sv
/*
  Checker for fpda_top: flash handshake, protection, code map, boot vector.
  Assumes it is bound to fpda_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module fpda_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        program_strobe_pin,
  input wire logic        par_en_pin,
  input wire logic        dl_valid,
  input wire logic        dl_erase,
  input wire logic [15:0] dl_addr,
  input wire logic [7:0]  dl_data,
  input wire logic        dl_ready,
  input wire logic        pf_req,
  input wire logic [1:0]  pf_op,
  input wire logic [15:0] pf_addr,
  input wire logic [7:0]  pf_wdata,
  input wire logic        pf_ack,
  input wire logic [15:0] code_addr,
  input wire logic        code_in_array,
  input wire logic [15:0] reset_vector
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // Sequences
  sequence s_dl_take;
    dl_valid && dl_ready && !dl_erase && dl_addr < 16'hf800;
  endsequence
  sequence s_pf_byte;
    pf_req && pf_op == 2'd0 && pf_addr == $past(dl_addr) && pf_wdata == $past(dl_data);
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == 8'h1c;
  endsequence
  // ==========================================
  // Properties
  property p_code_map;
    code_in_array == (code_addr < 16'hf800);
  endproperty
  property p_byte_below_top;
    pf_req && pf_op == 2'd0 |-> pf_addr < 16'hf800;
  endproperty
  // Bench pins stand for the latched mode
  property p_protect_top;
    pf_req && pf_op != 2'd2 && (pf_addr >= 16'he000 || pf_op == 2'd3) |-> !program_strobe_pin || par_en_pin;
  endproperty
  property p_runtime_only;
    pf_req && pf_op == 2'd2 |-> program_strobe_pin && !par_en_pin;
  endproperty
  property p_hold;
    pf_req && !pf_ack |=> pf_req && $stable(pf_addr) && $stable(pf_op) && $stable(pf_wdata);
  endproperty
  property p_drop;
    pf_req && pf_ack |=> !pf_req;
  endproperty
  property p_dl_write;
    s_dl_take |=> s_pf_byte;
  endproperty
  property p_dl_idle;
    dl_ready |-> !program_strobe_pin && !pf_req;
  endproperty
  property p_boot_vec;
    s_ctrl_wr |-> ##2 reset_vector == ($past(pwdata[1], 2) ? 16'he000 : 16'h0000);
  endproperty
  property p_decode;
    psel && penable |-> pready && pslverr == (paddr > 8'h20 || paddr[1:0] != 2'd0);
  endproperty
  a_code_map: assert property (p_code_map)
    else $error("code map flag wrong");
  a_byte_below_top: assert property (p_byte_below_top)
    else $error("byte write above array");
  a_protect_top: assert property (p_protect_top)
    else $error("protected region changed by user");
  a_runtime_only: assert property (p_runtime_only)
    else $error("lower erase outside runtime mode");
  a_hold: assert property (p_hold)
    else $error("flash request changed before ack");
  a_drop: assert property (p_drop)
    else $error("flash request kept after ack");
  a_dl_write: assert property (p_dl_write)
    else $error("download byte not forwarded");
  a_dl_idle: assert property (p_dl_idle)
    else $error("download ready out of mode");
  a_boot_vec: assert property (p_boot_vec)
    else $error("start vector wrong");
  a_decode: assert property (p_decode)
    else $error("address decode wrong");
endmodule

// File: verification/fpda_pflash_model.sv
/*
  Program flash macro and XRAM model facing fpda_top.
  Assumes one clock; acks after 0 or 3 wait cycles as slow selects.
*/
`timescale 1ns/100ps
module fpda_pflash_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        pf_req,
  input  wire logic [1:0]  pf_op,
  input  wire logic [15:0] pf_addr,
  input  wire logic [7:0]  pf_wdata,
  output logic             pf_ack,
  input  wire logic [7:0]  xram_addr,
  output logic [7:0]       xram_rdata
);
  logic [7:0] mem [65536];
  logic [7:0] xram [256];
  int         n_ops;
  int         cnt;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (xram[i]) xram[i] = 8'h00;
    n_ops = 0;
  end
  // ==========================================
  // XRAM answers one cycle after the address
  always @(posedge pclk)
    xram_rdata <= xram[xram_addr];
  // ==========================================
  // Flash operations
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pf_ack <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      pf_ack <= 1'b0;
      if (pf_req && !pf_ack)
      begin
        if (cnt < (slow ? 3 : 0))
          cnt <= cnt + 1;
        else
        begin
          pf_ack <= 1'b1;
          cnt <= 0;
          n_ops++;
          case (pf_op)
            // Programming only clears bits, so unerased targets show up
            2'd0: mem[pf_addr] = mem[pf_addr] & pf_wdata;
            2'd1: for (int i = 0; i < 64; i++) mem[{pf_addr[15:6], 6'h00} + i] = 8'hff;
            2'd2: for (int i = 0; i < 32'he000; i++) mem[i] = 8'hff;
            default: for (int i = 0; i < 32'hf800; i++) mem[i] = 8'hff;
          endcase
        end
      end
    end
endmodule

// File: verification/test_flash_program_data_access.sv
/*
  Self-checking bench for fpda_top with the program flash partner.
  Assumes the checker and the partner model are compiled first.
*/
`timescale 1ns/100ps
module test_flash_program_data_access;
  logic        pclk, presetn, psel, penable, pwrite, slow, err;
  logic        program_strobe_pin, par_en_pin, ale_pin, dl_valid, dl_erase;
  logic        pready, pslverr, dl_ready, pf_req, pf_ack, code_in_array;
  logic [7:0]  paddr, p0_pin, p1_pin, p2_pin, p3_pin, dl_data, xram_addr, xram_rdata, pf_wdata;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] dl_addr, pf_addr, code_addr, reset_vector, a16;
  logic [1:0]  pf_op;
  logic [7:0]  pg [4];
  logic [9:0]  page;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n0;

  fpda_top i_fpda_top (.*);
  fpda_pflash_model i_fpda_pflash_model (.*);

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Whole run needs about 7000 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: run hung", $time);
      wrap_up;
    end
  end
  // ==========================================
  // Tasks
  function automatic logic in_array(input logic [15:0] a);
    return a < 16'hf800;
  endfunction
  function automatic logic [7:0] fm(input logic [15:0] a);
    return i_fpda_pflash_model.mem[a];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    int k;
    k = 0;
    apb(1'b1, 8'h18, {24'h0, c});
    do
    begin
      apb(1'b0, 8'h20, 32'h0);
      k++;
    end while ((q[0] !== 1'b0 || pf_req !== 1'b0) && k < 3000);
    chk({31'h0, q[0] | pf_req}, 32'h0, "command done");
  endtask
  task automatic setpage(input logic [7:0] hi, input logic [7:0] lo);
    apb(1'b1, 8'h10, {24'h0, hi});
    apb(1'b1, 8'h14, {24'h0, lo});
  endtask
  task automatic do_reset(input logic pin);
    presetn <= 1'b0;
    program_strobe_pin <= pin;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  task automatic dl_send(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    dl_valid <= 1'b1;
    dl_addr <= a;
    dl_data <= d;
    do @(posedge pclk); while (dl_ready !== 1'b1);
    dl_valid <= 1'b0;
    @(posedge pclk);
    while (pf_req === 1'b1) @(posedge pclk);
  endtask
  task automatic par_op(input logic [1:0] cfg, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    p3_pin <= {6'h00, cfg};
    {p2_pin, p1_pin} <= a;
    p0_pin <= d;
    repeat (4) @(posedge pclk);
    ale_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    ale_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    while (pf_req === 1'b1) @(posedge pclk);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, slow, par_en_pin, ale_pin, dl_valid, dl_erase} = 8'h00;
    {paddr, p0_pin, p1_pin, p2_pin, p3_pin, dl_data} = 48'h0;
    {pwdata, dl_addr, code_addr} = 64'h0;
    presetn = 1'b0;
    program_strobe_pin = 1'b1;
    n0 = $urandom(88845);
    do_reset(1'b1);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0, "reset value");
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk({16'h0, reset_vector}, 32'h0, "vector at reset");
    for (int i = 0; i < 8; i++)
    begin
      a16 = (i < 2) ? 16'hf7ff + 16'(i) : 16'($urandom);
      code_addr <= a16;
      repeat (2) @(posedge pclk);
      chk({31'h0, code_in_array}, {31'h0, in_array(a16)}, "code map");
    end
    $display("test map finished");
    for (int t = 0; t < 5; t++)
    begin
      page = (t == 0) ? 10'h3ff : 10'($urandom);
      setpage({6'h00, page[9:8]}, page[7:0]);
      cmd(8'h05);
      cmd(8'h01);
      for (int b = 0; b < 4; b++)
      begin
        apb(1'b0, 8'(b * 4), 32'h0);
        chk(q, 32'hff, "erased byte");
        pg[b] = 8'($urandom);
        apb(1'b1, 8'(b * 4), {24'h0, pg[b]});
      end
      cmd(8'h02);
      for (int b = 0; b < 4; b++) apb(1'b1, 8'(b * 4), 32'h0);
      cmd(8'h01);
      for (int b = 0; b < 4; b++)
      begin
        apb(1'b0, 8'(b * 4), 32'h0);
        chk(q, {24'h0, pg[b]}, "page byte");
      end
      cmd(8'h04);
      apb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0, "verify match");
      apb(1'b1, 8'h00, {24'h0, ~pg[0]});
      cmd(8'h04);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, q != 32'h0}, 32'h1, "verify mismatch");
      setpage({4'h0, page[9:6]}, {page[5:0], 2'd2});
      cmd(8'h81);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, {24'h0, pg[2]}, "byte read");
    end
    cmd(8'h06);
    cmd(8'h01);
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'hff, "erased array");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h18, (i == 0) ? 32'h3 : 32'h7 + 32'(i));
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, q[0]}, 32'h0, "reserved code idle");
    end
    $display("test data finished");
    n0 = i_fpda_pflash_model.n_ops;
    setpage(8'h10, 8'h00);
    cmd(8'h02);
    cmd(8'h05);
    chk(i_fpda_pflash_model.n_ops, n0, "flash touched outside runtime");
    apb(1'b1, 8'h1c, 32'h1);
    slow <= 1'b1;
    for (int i = 0; i < 256; i++) i_fpda_pflash_model.xram[i] = 8'($urandom);
    i_fpda_pflash_model.mem[16'he000] = 8'h5a;
    cmd(8'h02);
    for (int i = 0; i < 256; i++)
      chk(fm({8'h10, 8'(i)}), i_fpda_pflash_model.xram[i], "copied byte");
    n0 = i_fpda_pflash_model.n_ops;
    setpage(8'he0, 8'h00);
    cmd(8'h02);
    setpage(8'hf0, 8'h40);
    cmd(8'h05);
    chk(i_fpda_pflash_model.n_ops, n0, "protected target touched");
    setpage(8'h10, 8'h47);
    cmd(8'h05);
    chk(fm(16'h107f), 8'hff, "page erased");
    chk(fm(16'h103f), i_fpda_pflash_model.xram[8'h3f], "page kept");
    cmd(8'h06);
    chk(fm(16'h1000), 8'hff, "lower erased");
    chk(fm(16'he000), 8'h5a, "boot region kept");
    apb(1'b1, 8'h1c, 32'h2);
    repeat (3) @(posedge pclk);
    chk({16'h0, reset_vector}, 32'he000, "boot vector");
    $display("test runtime finished");
    do_reset(1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, q[1]}, 32'h1, "serial mode");
    pg[0] = 8'($urandom);
    dl_send(16'hf000, pg[0]);
    chk(fm(16'hf000), pg[0], "download byte");
    dl_send(16'hf800, 8'h00);
    chk(fm(16'hf800), 8'hff, "beyond array");
    $display("test serial finished");
    do_reset(1'b1);
    par_en_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, q[2]}, 32'h1, "parallel mode");
    par_op(2'd0, 16'he123, pg[0]);
    chk(fm(16'he123), pg[0], "parallel byte");
    par_op(2'd1, 16'he123, 8'h00);
    chk(fm(16'he123), 8'hff, "parallel erase");
    par_op(2'd2, 16'h0000, 8'h00);
    chk(fm(16'he000), 8'hff, "parallel full erase");
    $display("test parallel finished");
    wrap_up;
  end
endmodule

bind fpda_top fpda_top_chk i_fpda_top_chk (.*);
